// ===== design/lic5_pkg.sv
// constants shared by the line interface control register bank
package lic5_pkg;

  // clock period of sys_clk_in in nanoseconds (250 MHz)
  localparam int unsigned LIC5_CLK_PERIOD_NS = 4;

  // time base for every timer of the block, in microseconds
  localparam int unsigned LIC5_TICK_US = 100;
  // cycles of sys_clk_in per time-base tick
  localparam int unsigned LIC5_TICK_CYCLES =
    (LIC5_TICK_US * 1000) / LIC5_CLK_PERIOD_NS;

  // register indices and their byte addresses on the bus
  localparam logic [7:0] LIC5_CTL5_IDX  = 8'h1F;
  localparam logic [7:0] LIC5_GND_IDX   = 8'h20;
  localparam logic [7:0] LIC5_CTL5_ADDR = {LIC5_CTL5_IDX[5:0], 2'b00};
  localparam logic [7:0] LIC5_GND_ADDR  = {LIC5_GND_IDX[5:0], 2'b00};

  // values after reset
  localparam logic [7:0] LIC5_CTL5_RST   = 8'h20;
  localparam logic [1:0] LIC5_RELAYS_RST = 2'h3;

  // field positions of the first control register
  localparam int unsigned LIC5_FULL_BIT   = 7;
  localparam int unsigned LIC5_SEIZE_HI   = 6;
  localparam int unsigned LIC5_SEIZE_LO   = 5;
  localparam int unsigned LIC5_EXTEND_BIT = 3;
  localparam int unsigned LIC5_HPF_BIT    = 1;
  localparam int unsigned LIC5_FLOOR_BIT  = 0;
  // writable bits of the first register; bits 4 and 2 store nothing
  localparam logic [7:0] LIC5_CTL5_WMASK = 8'hEB;

  // field positions of the ground start register
  localparam int unsigned LIC5_TIP_RELAY_BIT  = 1;
  localparam int unsigned LIC5_RING_RELAY_BIT = 0;

  // seize debounce lengths in milliseconds
  localparam int unsigned LIC5_SEIZE_512_MS = 512;
  localparam int unsigned LIC5_SEIZE_128_MS = 128;
  localparam int unsigned LIC5_SEIZE_64_MS  = 64;
  localparam int unsigned LIC5_SEIZE_8_MS   = 8;

  // release speeds in microseconds (fast one stays below 0.5 ms)
  localparam int unsigned LIC5_REL_FAST_US = 200;
  localparam int unsigned LIC5_REL_MID_US  = 3000;
  localparam int unsigned LIC5_REL_SLOW_US = 26000;

  // timer widths
  localparam int unsigned LIC5_CNT_W = 13;

  // the same lengths as counts of ticks
  localparam logic [LIC5_CNT_W-1:0] LIC5_SEIZE_512_TK =
    LIC5_CNT_W'(LIC5_SEIZE_512_MS * 1000 / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_SEIZE_128_TK =
    LIC5_CNT_W'(LIC5_SEIZE_128_MS * 1000 / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_SEIZE_64_TK =
    LIC5_CNT_W'(LIC5_SEIZE_64_MS * 1000 / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_SEIZE_8_TK =
    LIC5_CNT_W'(LIC5_SEIZE_8_MS * 1000 / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_REL_FAST_TK =
    LIC5_CNT_W'(LIC5_REL_FAST_US / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_REL_MID_TK =
    LIC5_CNT_W'(LIC5_REL_MID_US / LIC5_TICK_US);
  localparam logic [LIC5_CNT_W-1:0] LIC5_REL_SLOW_TK =
    LIC5_CNT_W'(LIC5_REL_SLOW_US / LIC5_TICK_US);

  // line voltage magnitude at or below which the reading is forced to zero
  localparam logic [7:0] LIC5_FLOOR_V = 8'h03;

endpackage

// ===== design/lic5_tick.sv
// restartable divider giving a one-cycle time-base pulse
`timescale 1ns/1ps
module lic5_tick
  import lic5_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LIC5_TICK_CYCLES
)
(
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  input  wire logic restart_in,
  output logic      tick_out
);

  // whole state of the divider
  typedef struct packed {
    logic [23:0] cnt;   // cycles since the last tick
    logic        tick;  // registered tick pulse
  } lic5_tick_state_type;

  lic5_tick_state_type state_q;  // registered state
  lic5_tick_state_type state_d;  // next state

  // count cycles; restart puts the next tick a full period away
  always_comb
  begin
    state_d      = state_q;
    state_d.tick = 1'b0;
    if (restart_in)
    begin
      state_d.cnt = 24'h000000;
    end
    else if (state_q.cnt == 24'(TICK_CYCLES - 1))
    begin
      state_d.cnt  = 24'h000000;
      state_d.tick = 1'b1;
    end
    else
    begin
      state_d.cnt = state_q.cnt + 24'h000001;
    end
  end

  // register the state
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign tick_out = state_q.tick;

endmodule

// ===== design/lic5_regs.sv
// line interface control five and ground start registers with timers
//
// How it works
// - bit 7 set selects full-scale converter mode
// - bits 6:5 pick 512/128/64/8 ms seize
// - extend, speed, damping pick release speed
// - release timed from seize clear to current
// - bit 1 picks 5 Hz or 200 Hz
// - bit 0 clear forces low voltages zero
// - forcing off passes raw reading, zero stays
// - tip sense bit reads zero during current while ground bit 1 is clear
// - ground bit 1 drives tip relay
// - ground bit 0 drives ring relay
// - ground bits 7:3 read zero
// - voltage reading signed; sign change flags reversal
`timescale 1ns/1ps
module lic5_regs
  import lic5_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LIC5_TICK_CYCLES
)
(
  input  wire logic        sys_clk_in,
  input  wire logic        srst_in,
  // avalon-mm slave
  input  wire logic [7:0]  address_in,
  input  wire logic        read_in,
  input  wire logic        write_in,
  input  wire logic [3:0]  byteenable_in,
  input  wire logic [31:0] writedata_in,
  output logic      [31:0] readdata_out,
  output logic             waitrequest_out,
  // line side status and control from elsewhere in the device
  input  wire logic        line_seize_bit_in,
  input  wire logic        release_speed_select_in,
  input  wire logic [1:0]  arc_damping_select_in,
  input  wire logic [7:0]  line_voltage_raw_in,
  input  wire logic        tip_earth_current_in,
  // effects of the registers
  output logic             full_scale_out,
  output logic             receive_highpass_select_out,
  output logic             seize_debounce_done_out,
  output logic             loop_current_enable_out,
  output logic [7:0]       line_voltage_reading_out,
  output logic             polarity_reversal_out,
  output logic             tip_earth_sense_relay_out,
  output logic             far_wire_earth_relay_out
);

  // whole state of the block
  typedef struct packed {
    logic                  wait_n;     // high while the bus must wait
    logic [31:0]           rdata;      // read data presented to the bus
    logic [7:0]            ctl5;       // first control register
    logic [1:0]            relays;     // ground start relay bits
    logic                  tip_sense;  // live tip sense, low on current with tip relay bit clear
    logic                  seize_prev; // seize level one cycle ago
    logic [LIC5_CNT_W-1:0] seize_cnt;  // debounce ticks elapsed
    logic                  seize_done; // debounce complete
    logic [LIC5_CNT_W-1:0] rel_cnt;    // release ticks elapsed
    logic                  releasing;  // release timer running
    logic                  loop_en;    // loop current permitted
    logic [7:0]            volt;       // line voltage reading
    logic                  volt_sign;  // sign of the previous sample
    logic                  volt_seen;  // a sample has been taken
    logic                  pol_rev;    // reversal pulse
  } lic5_state_type;

  lic5_state_type state_q;  // registered state
  lic5_state_type state_d;  // next state
  logic           tick;     // time-base pulse
  logic           restart;  // realigns the time base on seize edges

  // selects which register an address names: 0 none, 1 ctl5, 2 ground
  function automatic logic [1:0] lic5_sel(input logic [7:0] addr);
    logic [1:0] sel;
    sel = 2'h0;
    if (addr == LIC5_CTL5_ADDR)
    begin
      // first control register
      sel = 2'h1;
    end
    else if (addr == LIC5_GND_ADDR)
    begin
      // ground start register
      sel = 2'h2;
    end
    return sel;
  endfunction

  // seize debounce length in ticks from the two-bit field
  function automatic logic [LIC5_CNT_W-1:0] lic5_seize_len(
    input logic [1:0] code);
    logic [LIC5_CNT_W-1:0] len;
    // code one is the reset default of 128 ms
    // the default branch only catches unknown codes
    case (code)
      2'h0:    len = LIC5_SEIZE_512_TK;
      2'h1:    len = LIC5_SEIZE_128_TK;
      2'h2:    len = LIC5_SEIZE_64_TK;
      2'h3:    len = LIC5_SEIZE_8_TK;
      default: len = LIC5_SEIZE_128_TK;
    endcase
    return len;
  endfunction

  // release speed in ticks from speed, extend and damping settings
  // speed and damping come from other registers of the device
  function automatic logic [LIC5_CNT_W-1:0] lic5_rel_len(
    input logic       speed,
    input logic       extend,
    input logic [1:0] damp);
    logic [LIC5_CNT_W-1:0] len;
    // any combination not listed keeps the fast release
    len = LIC5_REL_FAST_TK;
    if (speed && (damp == 2'h3))
    begin
      // slow release, extend bit is a don't care
      len = LIC5_REL_SLOW_TK;
    end
    else if (!speed && extend && (damp == 2'h0))
    begin
      // medium release
      len = LIC5_REL_MID_TK;
    end
    return len;
  endfunction

  // true when a signed reading lies within the forced-zero band
  // both polarities share one band
  function automatic logic lic5_is_low(input logic [7:0] v);
    logic low;
    low = 1'b0;
    if (!v[7] && (v <= LIC5_FLOOR_V))
    begin
      // positive reading at or under the floor
      low = 1'b1;
    end
    else if (v[7] && ((~v + 8'h01) <= LIC5_FLOOR_V))
    begin
      // negative reading, magnitude at or under the floor
      low = 1'b1;
    end
    return low;
  endfunction

  // time base restarts on each seize edge so delays are exact
  // a tick already in flight is dropped by the restart
  assign restart = (line_seize_bit_in != state_q.seize_prev);

  // time base shared by the debounce and release timers
  // the first tick after an edge comes one full period later
  lic5_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk_in  (sys_clk_in),
    .srst_in     (srst_in),
    .restart_in  (restart),
    .tick_out    (tick)
  );

  // next-state logic of bus, registers, timers and line reading
  always_comb
  begin
    state_d         = state_q;
    // pulse outputs fall back low every cycle
    state_d.pol_rev = 1'b0;

    // bus: one wait cycle, then answer with waitrequest low
    // a new request is taken only while waitrequest is high
    if ((read_in || write_in) && state_q.wait_n)
    begin
      state_d.wait_n = 1'b0;
      case (lic5_sel(address_in))
        2'h1:
        begin
          // reserved bits are stored as zero already
          state_d.rdata = {24'h000000, state_q.ctl5};
        end
        2'h2:
        begin
          // upper bits always read zero
          state_d.rdata = {29'h00000000, state_q.tip_sense,
                           state_q.relays};
        end
        default:
        begin
          // unmapped addresses read as zero
          state_d.rdata = 32'h00000000;
        end
      endcase
    end
    else
    begin
      // idle, or answered: waitrequest goes back high
      state_d.wait_n = 1'b1;
    end

    // write takes effect on the edge with waitrequest low
    // only byte lane 0 carries register bits
    if (write_in && !state_q.wait_n && byteenable_in[0])
    begin
      case (lic5_sel(address_in))
        2'h1:
        begin
          // bits 4 and 2 store nothing, software keeps them zero
          state_d.ctl5 = writedata_in[7:0] & LIC5_CTL5_WMASK;
        end
        2'h2:
        begin
          // relay control bits
          state_d.relays = writedata_in[1:0];
        end
        default:
        begin
          // unmapped writes change nothing
          state_d.ctl5 = state_q.ctl5;
        end
      endcase
    end

    // tip sense low only while the relay is closed and current flows
    // an open relay hides the current, so the sense idles high
    state_d.tip_sense = ~(tip_earth_current_in &
                          ~state_q.relays[LIC5_TIP_RELAY_BIT]);

    // seize debounce: count ticks after seize, done at selected length
    state_d.seize_prev = line_seize_bit_in;
    if (!line_seize_bit_in)
    begin
      // line released: clear the debounce
      state_d.seize_cnt  = '0;
      state_d.seize_done = 1'b0;
    end
    else if (restart)
    begin
      // seize edge: count again from zero
      state_d.seize_cnt  = '0;
      state_d.seize_done = 1'b0;
    end
    else if (tick && !state_q.seize_done)
    begin
      // one more tick with the line held
      state_d.seize_cnt = state_q.seize_cnt + 1'b1;
      if (state_d.seize_cnt == lic5_seize_len(
            state_q.ctl5[LIC5_SEIZE_HI:LIC5_SEIZE_LO]))
      begin
        // selected length reached
        state_d.seize_done = 1'b1;
      end
    end

    // release: loop current ends the selected time after seize clears
    if (line_seize_bit_in)
    begin
      // seized, current flows at once
      state_d.loop_en   = 1'b1;
      state_d.releasing = 1'b0;
      state_d.rel_cnt   = '0;
    end
    else if (restart && state_q.loop_en)
    begin
      // seize just cleared, start timing
      state_d.releasing = 1'b1;
      state_d.rel_cnt   = '0;
    end
    else if (state_q.releasing && tick)
    begin
      // one more tick of release
      state_d.rel_cnt = state_q.rel_cnt + 1'b1;
      if (state_d.rel_cnt == lic5_rel_len(release_speed_select_in,
            state_q.ctl5[LIC5_EXTEND_BIT], arc_damping_select_in))
      begin
        // selected release time reached, current stops
        state_d.loop_en   = 1'b0;
        state_d.releasing = 1'b0;
      end
    end

    // line voltage reading, forced to zero near zero unless disabled
    if (!state_q.ctl5[LIC5_FLOOR_BIT] && lic5_is_low(line_voltage_raw_in))
    begin
      // inside the floor band with forcing enabled
      state_d.volt = 8'h00;
    end
    else
    begin
      // raw value passes; a raw zero still reads zero
      state_d.volt = line_voltage_raw_in;
    end

    // sign bit change marks a polarity reversal
    // the first sample after reset has no earlier sign
    state_d.volt_sign = state_d.volt[7];
    state_d.volt_seen = 1'b1;
    if (state_q.volt_seen && (state_d.volt[7] != state_q.volt_sign))
    begin
      state_d.pol_rev = 1'b1;
    end
  end

  // register the state; reset loads the documented defaults
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      // clear everything, then load the nonzero defaults
      state_q           <= '0;
      state_q.wait_n    <= 1'b1;
      state_q.ctl5      <= LIC5_CTL5_RST;
      state_q.relays    <= LIC5_RELAYS_RST;
      // tip sense idles high until the first sample
      state_q.tip_sense <= 1'b1;
    end
    else
    begin
      // normal operation
      state_q <= state_d;
    end
  end

  // outputs straight from the state flip-flops
  // bus answer
  assign readdata_out                = state_q.rdata;
  assign waitrequest_out             = state_q.wait_n;
  // converter scale select
  assign full_scale_out              = state_q.ctl5[LIC5_FULL_BIT];
  // receive corner select
  assign receive_highpass_select_out = state_q.ctl5[LIC5_HPF_BIT];
  // timer status
  assign seize_debounce_done_out     = state_q.seize_done;
  assign loop_current_enable_out     = state_q.loop_en;
  // line voltage reading and reversal pulse
  assign line_voltage_reading_out    = state_q.volt;
  assign polarity_reversal_out       = state_q.pol_rev;
  // relay drives, one means open
  assign tip_earth_sense_relay_out   =
    state_q.relays[LIC5_TIP_RELAY_BIT];
  assign far_wire_earth_relay_out    =
    state_q.relays[LIC5_RING_RELAY_BIT];

endmodule

// ===== dv/lic5_regs_sva.sv
// concurrent checks on the line interface control register bank ports
`timescale 1ns/1ps
module lic5_regs_sva
  import lic5_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        srst_in,
  input wire logic [7:0]  address_in,
  input wire logic        read_in,
  input wire logic        write_in,
  input wire logic [3:0]  byteenable_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic        waitrequest_out,
  input wire logic        line_seize_bit_in,
  input wire logic [7:0]  line_voltage_raw_in,
  input wire logic        full_scale_out,
  input wire logic        receive_highpass_select_out,
  input wire logic        seize_debounce_done_out,
  input wire logic        loop_current_enable_out,
  input wire logic [7:0]  line_voltage_reading_out,
  input wire logic        polarity_reversal_out,
  input wire logic        tip_earth_sense_relay_out,
  input wire logic        far_wire_earth_relay_out
);
  // accesses committing at this edge, per register
  wire logic go  = !waitrequest_out;
  wire logic we  = write_in && go && byteenable_in[0];
  wire logic wr5 = we && (address_in == LIC5_CTL5_ADDR);
  wire logic wrg = we && (address_in == LIC5_GND_ADDR);
  wire logic rd5 = read_in && go && (address_in == LIC5_CTL5_ADDR);
  wire logic rdg = read_in && go && (address_in == LIC5_GND_ADDR);
  // raw voltage outside the forced band of -3..3
  wire logic big = $signed(line_voltage_raw_in) > 3 ||
                   $signed(line_voltage_raw_in) < -3;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  a_wait_one: assert property ((read_in || write_in) && waitrequest_out
    |=> !waitrequest_out ##1 waitrequest_out) else $error("wait not one");
  a_reset_vals: assert property ($fell(srst_in) |->
    waitrequest_out && !full_scale_out && !receive_highpass_select_out &&
    tip_earth_sense_relay_out && far_wire_earth_relay_out)
    else $error("bad value after reset");
  a_full_scale: assert property (wr5 |=> ##1
    full_scale_out == $past(writedata_in[7], 2)) else $error("full scale");
  a_hpf_select: assert property (wr5 |=> ##1
    receive_highpass_select_out == $past(writedata_in[1], 2))
    else $error("highpass select");
  a_tip_relay: assert property (wrg |=> ##1
    tip_earth_sense_relay_out == $past(writedata_in[1], 2))
    else $error("tip relay");
  a_ring_relay: assert property (wrg |=> ##1
    far_wire_earth_relay_out == $past(writedata_in[0], 2))
    else $error("ring relay");
  a_gnd_reserved: assert property (rdg |-> readdata_out[31:3] == 0)
    else $error("ground reserved bits");
  a_ctl5_reserved: assert property (rd5 |-> readdata_out[31:8] == 0 &&
    readdata_out[4] == 0 && readdata_out[2] == 0) else $error("ctl5 rsvd");
  a_zero_volts: assert property (line_voltage_raw_in == 0 |=>
    line_voltage_reading_out == 0) else $error("zero volts not zero");
  a_raw_pass: assert property (big |=>
    line_voltage_reading_out == $past(line_voltage_raw_in))
    else $error("reading not raw");
  a_pol_pulse: assert property ($changed(line_voltage_reading_out[7])
    |-> ##[0:1] polarity_reversal_out) else $error("no reversal pulse");
  a_seize_enable: assert property ($rose(line_seize_bit_in) |=>
    loop_current_enable_out) else $error("loop current not enabled");
  a_debounce_drop: assert property (!line_seize_bit_in |=>
    !seize_debounce_done_out) else $error("debounce done while idle");
endmodule

bind lic5_regs lic5_regs_sva u_sva (
  .sys_clk_in(sys_clk_in), .srst_in(srst_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
  .writedata_in(writedata_in), .readdata_out(readdata_out),
  .waitrequest_out(waitrequest_out), .line_seize_bit_in(line_seize_bit_in),
  .line_voltage_raw_in(line_voltage_raw_in), .full_scale_out(full_scale_out),
  .receive_highpass_select_out(receive_highpass_select_out),
  .seize_debounce_done_out(seize_debounce_done_out),
  .loop_current_enable_out(loop_current_enable_out),
  .line_voltage_reading_out(line_voltage_reading_out),
  .polarity_reversal_out(polarity_reversal_out),
  .tip_earth_sense_relay_out(tip_earth_sense_relay_out),
  .far_wire_earth_relay_out(far_wire_earth_relay_out));

// ===== dv/lic5_regs_test.sv
// self-checking bench for the line interface control register bank
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lic5_regs_test
  import lic5_pkg::*;
;
  localparam int TK = 4;             // shortened time-base tick
  logic        sys_clk_in = 0;
  logic        srst_in = 1;
  logic [7:0]  address_in = 0;
  logic        read_in = 0;
  logic        write_in = 0;
  logic [3:0]  byteenable_in = 4'hF;
  logic [31:0] writedata_in = 0;
  logic        seize = 0;            // line seize state
  logic        speed = 0;            // release speed select
  logic [1:0]  damp = 0;             // arc damping select
  logic [7:0]  raw = 0;              // raw line voltage
  logic        tip_cur = 0;          // tip ground current
  wire  [31:0] readdata_out;
  wire         waitrequest_out, full_scale_out, hpf_out, done_out, loop_en;
  wire  [7:0]  reading;
  wire         pol_out, tip_rly, ring_rly;
  int          mismatches = 0, compares = 0, cycles = 0, pol_cnt = 0, n;
  logic [7:0]  rd;
  logic [7:0]  vin[7] = '{8'h14, 8'h03, 8'hFD, 8'h04, 8'hEC, 8'h03, 8'h00};
  logic [7:0]  vex[7] = '{8'h14, 8'h00, 8'h00, 8'h04, 8'hEC, 8'h03, 8'h00};
  int          dn[4] = '{5120, 1280, 640, 80};
  logic [3:0]  rc[3] = '{4'hB, 4'h4, 4'h0};  // speed, extend, damping
  int          rm[3] = '{260, 30, 2};

  lic5_regs #(.TICK_CYCLES(TK)) DUT (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .byteenable_in(byteenable_in),
    .writedata_in(writedata_in), .readdata_out(readdata_out),
    .waitrequest_out(waitrequest_out), .line_seize_bit_in(seize),
    .release_speed_select_in(speed), .arc_damping_select_in(damp),
    .line_voltage_raw_in(raw), .tip_earth_current_in(tip_cur),
    .full_scale_out(full_scale_out), .receive_highpass_select_out(hpf_out),
    .seize_debounce_done_out(done_out), .loop_current_enable_out(loop_en),
    .line_voltage_reading_out(reading), .polarity_reversal_out(pol_out),
    .tip_earth_sense_relay_out(tip_rly), .far_wire_earth_relay_out(ring_rly));

  // clock at 250 MHz
  always #2 sys_clk_in = ~sys_clk_in;

  // hang guard and reversal pulse count
  always @(posedge sys_clk_in)
  begin
    cycles++;
    if (pol_out === 1'b1) pol_cnt++;
    if (cycles == 60000)
    begin
      mismatches++;
      summarize;
    end
  end

  // verdict and end of run
  task summarize;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // avalon write, held until waitrequest is sampled low
  task bus_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge sys_clk_in);
    address_in <= a;
    writedata_in <= {24'h0, d};
    byteenable_in <= be;
    write_in <= 1'b1;
    do @(posedge sys_clk_in); while (waitrequest_out !== 1'b0);
    write_in <= 1'b0;
  endtask

  // avalon read and compare of the low byte
  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    address_in <= a;
    read_in <= 1'b1;
    do @(posedge sys_clk_in); while (waitrequest_out !== 1'b0);
    rd = readdata_out[7:0];
    read_in <= 1'b0;
    `CHK(rd, e)
  endtask

  // let register effects reach the outputs
  task settle;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // cycles until debounce done rises, or loop enable falls
  task measure(input bit dbn, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge sys_clk_in);
      cnt++;
    end
    while ((dbn ? done_out : !loop_en) !== 1'b1 && cnt < 30000);
  endtask

  initial
  begin
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rd_chk(LIC5_CTL5_ADDR, 8'h20);
    rd_chk(LIC5_GND_ADDR, 8'h07);
    // loop dc and least current fields sit in other registers
    bus_wr(LIC5_CTL5_ADDR, 8'hEB, 4'hF);
    rd_chk(LIC5_CTL5_ADDR, 8'hEB);
    settle;
    `CHK({full_scale_out, hpf_out}, 2'b11)
    bus_wr(LIC5_CTL5_ADDR, 8'h00, 4'hE);  // low lane off: ignored
    rd_chk(LIC5_CTL5_ADDR, 8'hEB);
    bus_wr(LIC5_CTL5_ADDR, 8'h00, 4'hF);
    settle;
    `CHK({full_scale_out, hpf_out}, 2'b00)
    bus_wr(8'h84, 8'hFF, 4'hF);  // unmapped place
    rd_chk(8'h84, 8'h00);
    bus_wr(LIC5_GND_ADDR, 8'hF8, 4'hF);
    rd_chk(LIC5_GND_ADDR, 8'h04);
    `CHK({tip_rly, ring_rly}, 2'b00)
    tip_cur <= 1'b1;
    settle;
    rd_chk(LIC5_GND_ADDR, 8'h00);
    bus_wr(LIC5_GND_ADDR, 8'h02, 4'hF);
    settle;
    `CHK({tip_rly, ring_rly}, 2'b10)
    rd_chk(LIC5_GND_ADDR, 8'h06);
    tip_cur <= 1'b0;
    bus_wr(LIC5_GND_ADDR, 8'h01, 4'hF);
    settle;
    `CHK({tip_rly, ring_rly}, 2'b01)
    rd_chk(LIC5_GND_ADDR, 8'h05);
    // voltage floor forced, then released from entry 5 on
    for (int i = 0; i < 7; i++)
    begin
      if (i == 5) bus_wr(LIC5_CTL5_ADDR, 8'h01, 4'hF);
      raw <= vin[i];
      settle;
      `CHK(reading, vex[i])
    end
    `CHK(pol_cnt, 2)
    // every seize debounce code
    for (int c = 0; c < 4; c++)
    begin
      bus_wr(LIC5_CTL5_ADDR, 8'(c << 5), 4'hF);
      seize <= 1'b1;
      measure(1'b1, n);
      `CHK(n >= dn[c] * TK - 2 && n <= dn[c] * TK + 3, 1'b1)
      `CHK(loop_en, 1'b1)
      seize <= 1'b0;
      settle;
      `CHK(done_out, 1'b0)
      settle;
    end
    // release speeds
    for (int r = 0; r < 3; r++)
    begin
      bus_wr(LIC5_CTL5_ADDR, {4'h0, rc[r][2], 3'h0}, 4'hF);
      speed <= rc[r][3];
      damp <= rc[r][1:0];
      seize <= 1'b1;
      settle;
      seize <= 1'b0;
      measure(1'b0, n);
      `CHK(n >= rm[r] * TK - 2 && n <= rm[r] * TK + 3, 1'b1)
    end
    summarize;
  end
endmodule
